// ---- core/pfm_pkg.sv ----
package pfm_pkg;

	// System clock and the free-running payload bit clock.
	localparam int CLK_HZ         = 100_000_000;
	localparam int BIT_HZ         = 2_048_000;
	localparam int BIT_PPM_TOL    = 50;
	// Common divisor of the two rates, so the phase accumulator stays exact.
	localparam int CLK_GCD_HZ     = 32_000;
	localparam int ACC_MOD        = CLK_HZ / CLK_GCD_HZ;
	localparam int ACC_INC        = BIT_HZ / CLK_GCD_HZ;
	localparam int ACC_W          = 12;

	// Core frame layout.
	localparam int FRAME_TIME_US    = 500;
	localparam int CORE_FRAME_BYTES = 144;
	localparam int PAYLOAD_BYTES    = 128;
	localparam int STUFF_BYTES      = 16;
	localparam int STUFF_GROUP      = 8;
	localparam int STUFF_PERIOD     = CORE_FRAME_BYTES / STUFF_BYTES;
	localparam int FRAME_BITS       = PAYLOAD_BYTES * 8;
	localparam logic [7:0] STUFF_FILL = 8'hFF;
	localparam logic [7:0] IDX_LAST   = 8'(CORE_FRAME_BYTES - 1);
	localparam logic [3:0] STUFF_SLOT = 4'(STUFF_PERIOD - 1);
	localparam logic [9:0] FBIT_LAST  = 10'(FRAME_BITS - 1);

	// Spare overhead bits of the line frame, sent as ONE.
	localparam int SPARE_OVERHEAD_BIT_FIRST = 9;
	localparam int SPARE_OVERHEAD_BIT_LAST  = 48;
	localparam int SPARE_W = SPARE_OVERHEAD_BIT_LAST - SPARE_OVERHEAD_BIT_FIRST + 1;
	localparam logic [SPARE_W-1:0] SPARE_FILL = '1;

	// Transfer delay budget in microseconds.
	localparam int DELAY_TOTAL_US = 1250;
	localparam int DELAY_LINE_TERM_US = 450;
	localparam int DELAY_NET_TERM_US  = 450;
	localparam int DELAY_REG_US   = 200;
	localparam int DELAY_LINE_US  = 150;
	// A longest time rounds down to whole cycles.
	localparam int DELAY_LINE_TERM_CYC = (DELAY_LINE_TERM_US * (CLK_HZ / 1_000_000));

	localparam int PAIRS_DEF = 3;

	// Frame mapper states, one-hot.
	typedef enum logic [1:0] {
		PFM_IDLE = 2'b01,
		PFM_RUN  = 2'b10
	} pfm_frame_state_t;

	// Per transceiver pair indications from the line core.
	typedef struct packed {
		logic activated;
		logic idOk;
		logic fault;
		logic signalLoss;
		logic frameAlignmentLoss;
	} pfm_pair_t;

	// One core frame byte handed to the transceiver core.
	typedef struct packed {
		logic       valid;
		logic       frameStart;
		logic       stuff;
		logic [7:0] data;
	} pfm_core_byte_t;

	// Section status towards the interface block.
	typedef struct packed {
		logic operational;
		logic lineLoss;
		logic activeInd;
	} pfm_status_t;

endpackage : pfm_pkg

// ---- core/pfm_bit_clock.sv ----
`timescale 1ns/1ps
module pfm_bit_clock
	import pfm_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic nrst,
	output logic      bitTick
);

	typedef struct packed {
		logic [ACC_W-1:0] acc;
		logic             tick;
	} pfm_clk_state_t;

	pfm_clk_state_t st_r;
	pfm_clk_state_t st_nxt;

	// Fractional divider: exact 2048 kHz on average, so the tolerance is
	// that of the system clock alone; edge jitter is one system period.
	always_comb begin
		st_nxt      = st_r;
		st_nxt.tick = 1'b0;
		if (st_r.acc + ACC_W'(ACC_INC) >= ACC_W'(ACC_MOD)) begin
			st_nxt.acc  = st_r.acc + ACC_W'(ACC_INC) - ACC_W'(ACC_MOD);
			st_nxt.tick = 1'b1;
		end else begin
			st_nxt.acc = st_r.acc + ACC_W'(ACC_INC);
		end
	end

	// State register.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign bitTick = st_r.tick;

endmodule : pfm_bit_clock

// ---- core/pfm_section_status.sv ----
`timescale 1ns/1ps
module pfm_section_status
	import pfm_pkg::*;
#(
	parameter int NUM_PAIRS = PAIRS_DEF
)(
	input  wire logic                      clk_sys,
	input  wire logic                      nrst,
	input  wire logic                      frameTick,
	input  wire pfm_pair_t [NUM_PAIRS-1:0] pairIn,
	output pfm_status_t                    status
);

	logic [NUM_PAIRS-1:0] pairGood;
	logic [NUM_PAIRS-1:0] pairBad;
	logic [NUM_PAIRS-1:0] pairLoss;

	// Per pair health terms.
	genvar g;
	generate
		for (g = 0; g < NUM_PAIRS; g++) begin : gPair
			assign pairGood[g] = pairIn[g].activated & pairIn[g].idOk & ~pairIn[g].fault;
			assign pairBad[g]  = ~pairIn[g].activated | ~pairIn[g].idOk | pairIn[g].fault;
			assign pairLoss[g] = pairIn[g].signalLoss | pairIn[g].frameAlignmentLoss;
		end
	endgenerate

	pfm_status_t st_r;
	pfm_status_t st_nxt;

	// Going down is immediate, coming up waits for a frame boundary so a
	// flickering pair cannot toggle the section faster than once a frame.
	always_comb begin
		st_nxt = st_r;
		if (|pairBad) begin
			st_nxt.operational = 1'b0;
		end else if (frameTick) begin
			st_nxt.operational = &pairGood;
		end
		st_nxt.lineLoss  = |pairLoss;
		st_nxt.activeInd = st_nxt.operational & ~(|pairLoss);
	end

	// State register.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign status = st_r;

endmodule : pfm_section_status

// ---- core/pfm_frame_mapper.sv ----
// Overview of operation
// - Map 2048 kbit/s payload into 144-byte frames.
// - 128 payload bytes, 16 all-ONE stuffing bytes.
// - Payload timeslot zero may start anywhere.
// - Payload framing loss never resynchronizes transceivers.
// - Spare overhead bits 9 to 48 sent ONE.
// - Operational only when all pairs good.
// - Any bad pair makes section non-operational.
// - Exchange-side request loops every pair back.
// - Management function inside termination unit controls loopback.
// - Provide line loss and active indications.
// - One-way delay at most 1250 microseconds.
// - Budget 450 per unit, 200 repeater, 150 line.
// - Network unit clock 2048 kHz, 50 ppm.
// - Line unit clock 2048 kHz, 50 ppm.
`timescale 1ns/1ps
module pfm_frame_mapper
	import pfm_pkg::*;
#(
	parameter int NUM_PAIRS       = PAIRS_DEF,
	parameter int DELAY_LIMIT_CYC = DELAY_LINE_TERM_CYC
)(
	input  wire logic                      clk_sys,
	input  wire logic                      nrst,
	// Application side, logic on the same clock.
	output logic                           appBitTick,
	input  wire logic                      appBitIn,
	// Transceiver core side.
	input  wire logic                      coreByteReq,
	output pfm_core_byte_t                 coreByte,
	output logic [SPARE_W-1:0]             spareOverhead,
	// Pair indications and section status.
	input  wire pfm_pair_t [NUM_PAIRS-1:0] pairIn,
	output pfm_status_t                    sectionStatus,
	// Loopback control.
	input  wire logic                      loopbackReq,
	input  wire logic                      loopbackPermit,
	output logic [NUM_PAIRS-1:0]           pairLoopback,
	// Data path health.
	output logic                           underrun,
	output logic                           overrun,
	output logic                           delayExceeded
);

	localparam int AGE_W = $clog2(DELAY_LIMIT_CYC + 1);
	localparam logic [AGE_W-1:0] AGE_LIMIT = AGE_W'(DELAY_LIMIT_CYC);

	typedef struct packed {
		pfm_frame_state_t     fsm;
		logic [7:0]           shift;
		logic [2:0]           bitCnt;
		logic [7:0]           hold;
		logic                 holdValid;
		logic [7:0]           byteIdx;
		logic [3:0]           stuffPh;
		logic [9:0]           frameBit;
		logic                 frameTick;
		pfm_core_byte_t       out;
		logic                 underrun;
		logic                 overrun;
		logic [AGE_W-1:0]     age;
		logic                 delayExc;
		logic [NUM_PAIRS-1:0] loop;
		logic [SPARE_W-1:0]   spare;
	} pfm_map_state_t;

	pfm_map_state_t st_r;
	pfm_map_state_t st_nxt;

	logic                 bitTick;
	logic [NUM_PAIRS-1:0] loopReqPair;

	// Free-running payload bit clock.
	pfm_bit_clock u_bitClock (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.bitTick (bitTick)
	);

	// Section status; operational rises only on a payload frame boundary, all else follows every cycle.
	pfm_section_status #(
		.NUM_PAIRS (NUM_PAIRS)
	) u_status (
		.clk_sys   (clk_sys),
		.nrst      (nrst),
		.frameTick (st_r.frameTick),
		.pairIn    (pairIn),
		.status    (sectionStatus)
	);

	// Loopback sits nearest the line in every pair; only the management
	// permit can let an exchange-side request through.
	genvar g;
	generate
		for (g = 0; g < NUM_PAIRS; g++) begin : gLoop
			assign loopReqPair[g] = loopbackReq & loopbackPermit;
		end
	endgenerate

	// Mapper next-state logic.
	always_comb begin
		logic byteDone;
		logic takeByte;
		logic isStuff;
		byteDone = 1'b0;
		takeByte = 1'b0;
		isStuff  = 1'b0;
		st_nxt           = st_r;
		st_nxt.frameTick = 1'b0;
		st_nxt.underrun  = 1'b0;
		st_nxt.overrun   = 1'b0;
		st_nxt.out.valid = 1'b0;
		st_nxt.loop      = loopReqPair;
		st_nxt.spare     = SPARE_FILL;

		// Bits are grouped eight at a time as they come; no search for
		// the payload's own frame word is made, so its loss has no effect.
		if (bitTick) begin
			st_nxt.shift  = {st_r.shift[6:0], appBitIn};
			st_nxt.bitCnt = st_r.bitCnt + 3'd1;
			byteDone      = (st_r.bitCnt == 3'd7);
			if (st_r.frameBit == FBIT_LAST) begin
				st_nxt.frameBit  = '0;
				st_nxt.frameTick = 1'b1;
			end else begin
				st_nxt.frameBit = st_r.frameBit + 10'd1;
			end
		end

		// Core byte slot: stuffing every ninth byte, payload otherwise.
		if (coreByteReq) begin
			isStuff          = (st_r.stuffPh == STUFF_SLOT);
			st_nxt.out.valid = 1'b1;
			st_nxt.out.frameStart = (st_r.byteIdx == 8'd0);
			st_nxt.out.stuff = isStuff;
			if (isStuff) begin
				st_nxt.out.data = STUFF_FILL;
			end else if (st_r.holdValid) begin
				st_nxt.out.data = st_r.hold;
				takeByte        = 1'b1;
			end else begin
				// Nothing to send yet: fill with ONEs.
				st_nxt.out.data = STUFF_FILL;
				st_nxt.underrun = (st_r.fsm == PFM_RUN);
			end
			if (st_r.byteIdx == IDX_LAST) begin
				st_nxt.byteIdx = '0;
				st_nxt.stuffPh = '0;
			end else begin
				st_nxt.byteIdx = st_r.byteIdx + 8'd1;
				st_nxt.stuffPh = isStuff ? 4'd0 : st_r.stuffPh + 4'd1;
			end
		end

		// Holding byte: a new byte wins over the take in the same cycle.
		if (byteDone) begin
			st_nxt.hold      = {st_r.shift[6:0], appBitIn};
			st_nxt.holdValid = 1'b1;
			st_nxt.overrun   = st_r.holdValid & ~takeByte;
			st_nxt.age       = '0;
		end else if (takeByte) begin
			st_nxt.holdValid = 1'b0;
			st_nxt.age       = '0;
		end else if (st_r.holdValid && st_r.age != AGE_LIMIT) begin
			st_nxt.age = st_r.age + AGE_W'(1);
		end

		// A byte held past the unit's share of the delay is flagged.
		st_nxt.delayExc = st_r.holdValid & (st_r.age == AGE_LIMIT);

		// Frame state: run once the first payload byte is ready.
		case (st_r.fsm)
			PFM_IDLE: begin
				if (st_nxt.holdValid) begin
					st_nxt.fsm = PFM_RUN;
				end
			end
			PFM_RUN: begin
				st_nxt.fsm = PFM_RUN;
			end
			default: begin
				st_nxt.fsm = PFM_IDLE;
			end
		endcase
	end

	// State register; spare overhead leaves reset already all ONE.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st_r       <= '0;
			st_r.fsm   <= PFM_IDLE;
			st_r.spare <= SPARE_FILL;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from the state register; appBitTick straight from the bit clock.
	assign appBitTick    = bitTick;
	assign coreByte      = st_r.out;
	assign spareOverhead = st_r.spare;
	assign pairLoopback  = st_r.loop;
	assign underrun      = st_r.underrun;
	assign overrun       = st_r.overrun;
	assign delayExceeded = st_r.delayExc;

endmodule : pfm_frame_mapper

// ---- sim/pfm_core_model.sv ----
`timescale 1ns/1ps
// Transceiver core side: asks for core frame bytes with a spacing set by the bench.
module pfm_core_model
	import pfm_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	input  wire logic [15:0] gap,
	output logic             coreByteReq
);
	int waitCnt = 0;

	// One-cycle request after gap idle cycles; a gap of zero asks back to back.
	initial coreByteReq = 1'b0;
	always @(posedge clk_sys) begin
		#1;
		coreByteReq <= nrst && (waitCnt >= gap);
		waitCnt = (nrst && waitCnt < gap) ? waitCnt + 1 : 0;
	end
endmodule : pfm_core_model

// ---- sim/pfm_frame_mapper_sva.sv ----
`timescale 1ns/1ps
module pfm_frame_mapper_sva
	import pfm_pkg::*;
#(
	parameter int NUM_PAIRS = PAIRS_DEF
)(
	input wire logic                      clk_sys,
	input wire logic                      nrst,
	input wire logic                      appBitTick,
	input wire logic                      coreByteReq,
	input wire pfm_core_byte_t            coreByte,
	input wire logic [SPARE_W-1:0]        spareOverhead,
	input wire pfm_pair_t [NUM_PAIRS-1:0] pairIn,
	input wire pfm_status_t               sectionStatus,
	input wire logic                      loopbackReq,
	input wire logic                      loopbackPermit,
	input wire logic [NUM_PAIRS-1:0]      pairLoopback
);
	logic bad;
	logic loss;

	// Any pair that blocks operation, and any line-side loss, folded over all pairs.
	always_comb begin
		bad = 1'b0;
		loss = 1'b0;
		for (int i = 0; i < NUM_PAIRS; i++) begin
			bad |= !pairIn[i].activated || !pairIn[i].idOk || pairIn[i].fault;
			loss |= pairIn[i].signalLoss || pairIn[i].frameAlignmentLoss;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	a_byte_answer: assert property (coreByteReq |=> coreByte.valid)
		else $error("core byte not answered one cycle after request");
	a_byte_lone: assert property (!coreByteReq |=> !coreByte.valid)
		else $error("core byte valid without a request");
	a_stuff_ones: assert property (coreByte.valid && coreByte.stuff |-> coreByte.data == STUFF_FILL)
		else $error("stuffing byte not all ones");
	a_spare_ones: assert property (spareOverhead == SPARE_FILL)
		else $error("spare overhead bits not all ones");
	a_tick_gap: assert property (appBitTick |=> !appBitTick [*8])
		else $error("bit strobes too close together");
	a_tick_rate: assert property (appBitTick |-> ##[48:49] appBitTick)
		else $error("bit strobe spacing off rate");
	a_op_needs_good: assert property (sectionStatus.operational |-> !$past(bad))
		else $error("operational while a pair was bad");
	a_op_drop: assert property (bad |=> !sectionStatus.operational)
		else $error("operational not dropped after bad pair");
	a_loss_follow: assert property (loss |=> sectionStatus.lineLoss)
		else $error("line loss not reported");
	a_loop_on: assert property (loopbackReq && loopbackPermit |=> &pairLoopback)
		else $error("loopback not set on every pair");
	a_loop_off: assert property (!(loopbackReq && loopbackPermit) |=> pairLoopback == '0)
		else $error("loopback set without permitted request");
endmodule : pfm_frame_mapper_sva

bind pfm_frame_mapper pfm_frame_mapper_sva #(.NUM_PAIRS(NUM_PAIRS)) u_sva (
	.clk_sys(clk_sys), .nrst(nrst), .appBitTick(appBitTick), .coreByteReq(coreByteReq),
	.coreByte(coreByte), .spareOverhead(spareOverhead), .pairIn(pairIn),
	.sectionStatus(sectionStatus), .loopbackReq(loopbackReq),
	.loopbackPermit(loopbackPermit), .pairLoopback(pairLoopback));

// ---- sim/pfm_frame_mapper_tb.sv ----
`timescale 1ns/1ps
module pfm_frame_mapper_tb;
	import pfm_pkg::*;
	localparam int NP = PAIRS_DEF;
	localparam int DLY = 200;
	logic               clk_sys = 1'b0;
	logic               nrst, appBitTick, appBitIn, coreByteReq;
	logic               loopbackReq, loopbackPermit, underrun, overrun, delayExceeded;
	logic [15:0]        gap;
	pfm_core_byte_t     coreByte;
	pfm_status_t        sectionStatus;
	pfm_pair_t [NP-1:0] pairIn;
	logic [NP-1:0]      pairLoopback;
	logic [SPARE_W-1:0] spareOv;
	logic [7:0]         sh, hold;
	logic [10:0]        e;
	logic [10:0]        q[$];
	int                 fail_count = 0, tests_run = 0, nb, idx, ovr, dOvr, p;
	int                 k, dExM, dExD, age;
	bit                 full, seen, nw, fp;

	always #5 clk_sys = ~clk_sys;

	pfm_frame_mapper #(.NUM_PAIRS(NP), .DELAY_LIMIT_CYC(DLY)) dut (
		.clk_sys(clk_sys), .nrst(nrst), .appBitTick(appBitTick), .appBitIn(appBitIn),
		.coreByteReq(coreByteReq), .coreByte(coreByte), .spareOverhead(spareOv),
		.pairIn(pairIn), .sectionStatus(sectionStatus), .loopbackReq(loopbackReq),
		.loopbackPermit(loopbackPermit), .pairLoopback(pairLoopback),
		.underrun(underrun), .overrun(overrun), .delayExceeded(delayExceeded));

	pfm_core_model core (.clk_sys(clk_sys), .nrst(nrst), .gap(gap), .coreByteReq(coreByteReq));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : step

	task automatic summarize();
		$display("checks=%0d mismatches=%0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : summarize

	// Fresh random payload bit every cycle; the mapper keeps only strobed ones.
	always @(posedge clk_sys) begin
		#1;
		appBitIn = 1'($urandom);
	end

	// Reference: MSB-first bytes, one holding byte, every ninth slot stuffed.
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			{nb, idx, ovr, dOvr, dExM, dExD, age, full, seen} = '0;
			q.delete();
		end else begin
			if (coreByte.valid) chk({underrun, coreByte.stuff, coreByte.frameStart, coreByte.data}, q.pop_front());
			// The held byte's age, as the design must count it, sets the expected flag.
			fp = full;
			if (full && age == DLY) dExM++;
			nw = 1'b0;
			if (appBitTick) begin
				sh = {sh[6:0], appBitIn};
				nb = (nb + 1) % 8;
				nw = (nb == 0);
			end
			if (coreByteReq) begin
				if (idx % 9 == 8) e = {2'b01, 1'b0, 8'hFF};
				else if (full) e = {2'b00, idx == 0, hold};
				else e = {seen, 1'b0, idx == 0, 8'hFF};
				full = full && (idx % 9 == 8);
				q.push_back(e);
				idx = (idx + 1) % CORE_FRAME_BYTES;
			end
			if (nw) begin
				if (full) ovr++;
				hold = sh;
				{full, seen} = 2'b11;
			end
			if (nw || (fp && !full)) age = 0;
			else if (full && age != DLY) age++;
			if (overrun) dOvr++;
			if (delayExceeded) dExD++;
		end
	end

	// Steady, flooding and stalling core, then status and loopback.
	initial begin
		void'($urandom(32'h2048));
		{nrst, loopbackReq, loopbackPermit} = '0;
		gap = 16'd345;
		pairIn = {NP{5'b01000}};
		step(12);
		nrst = 1'b1;
		step(25000);
		gap = 16'd0;
		step(400);
		gap = 16'd900;
		step(8000);
		// The registered flags still carry the last edge's event, so add them in.
		chk(16'(dOvr + overrun), 16'(ovr));
		chk(16'(dExD + delayExceeded), 16'(dExM));
		chk(16'(spareOv === SPARE_FILL), 16'h1);
		pairIn = {NP{5'b11000}};
		for (p = 0; p < 52000 && sectionStatus.operational !== 1'b1; p++) step(1);
		chk(16'(sectionStatus), 16'h5);
		p = $urandom % NP;
		e = 11'($urandom % 3);
		pairIn[p] = (e == 0) ? 5'b01000 : (e == 1) ? 5'b10000 : 5'b11100;
		step(2);
		chk(16'(sectionStatus.operational), 16'h0);
		// Each loss kind alone, with a clean step between them.
		for (k = 0; k < 4; k++) begin
			pairIn[p][1:0] = {k[1] & k[0], !k[1] & k[0]};
			step(2);
			chk(16'({sectionStatus.lineLoss, sectionStatus.activeInd}), 16'({k[0], 1'b0}));
		end
		for (p = 0; p < 4; p++) begin
			{loopbackReq, loopbackPermit} = p[1:0];
			step(2);
			chk(16'(pairLoopback), 16'({NP{p == 3}}));
		end
		summarize();
	end

	// A hang past the expected run length counts as a mismatch.
	initial begin
		repeat (95000) @(posedge clk_sys);
		fail_count++;
		summarize();
	end
endmodule : pfm_frame_mapper_tb
